// ### inc/stm_pkg.sv
// Shared constants for the standard timer operating-mode block
package stm_pkg;
    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [3:0] STM_REG_CTRL0 = 4'h0;
    localparam logic [3:0] STM_REG_CTRL1 = 4'h1;
    localparam logic [3:0] STM_REG_CNT_L = 4'h2;
    localparam logic [3:0] STM_REG_CNT_H = 4'h3;
    localparam logic [3:0] STM_REG_CMPA_L = 4'h4;
    localparam logic [3:0] STM_REG_CMPA_H = 4'h5;
    localparam logic [3:0] STM_REG_CMPP = 4'h6;
    localparam logic [3:0] STM_REG_FLAGS = 4'h7;
    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int STM_RUN_BIT = 0;
    localparam int STM_MODE_HI = 7;
    localparam int STM_MODE_LO = 6;
    localparam int STM_IO_HI = 5;
    localparam int STM_IO_LO = 4;
    localparam int STM_OC_BIT = 3;
    localparam int STM_POL_BIT = 2;
    localparam int STM_DPX_BIT = 1;
    localparam int STM_CCLR_BIT = 0;
    localparam int STM_FLAG_A_BIT = 0;
    localparam int STM_FLAG_P_BIT = 1;
    // ********************************************************
    // Encodings and reset values
    // ********************************************************
    localparam logic [1:0] STM_MODE_CMP = 2'h0;
    localparam logic [1:0] STM_MODE_CAP = 2'h1;
    localparam logic [1:0] STM_MODE_PWM = 2'h2;
    localparam logic [1:0] STM_MODE_TMR = 2'h3;
    localparam logic [1:0] STM_IO_00 = 2'h0;
    localparam logic [1:0] STM_IO_01 = 2'h1;
    localparam logic [1:0] STM_IO_10 = 2'h2;
    localparam logic [1:0] STM_IO_11 = 2'h3;
    localparam logic [7:0] STM_CTRL_RST = 8'h00;
    localparam logic [15:0] STM_CNT_MAX = 16'hffff;
    localparam logic [7:0] STM_DATA_ZERO = 8'h00;
endpackage

// ### rtl/stm_edge.sv
// Edge detector for a pin taken as synchronous to the clock
`timescale 1ns/1ps
`default_nettype none
module stm_edge (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_rise,
    output logic o_fall
);
    logic prev_q;
    logic prev_d;

    // Previous level, next value
    always_comb begin
        prev_d = i_pin;
    end

    // Reset to low so a pin held high at reset reads as one rising edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // Edge pulses, one cycle each
    assign o_rise = i_pin & ~prev_q;
    assign o_fall = ~i_pin & prev_q;
endmodule
`default_nettype wire

// ### rtl/stm_timer.sv
// Standard timer: counter, comparators, output pin, capture, registers
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module stm_timer
    import stm_pkg::*;
#(
    parameter int TICK_DIV = 1
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    input wire logic I_CAP_PIN,
    input wire logic I_TRIG_PIN,
    output logic O_TMR_OUT,
    output logic O_TMR_OE
);
    // ********************************************************
    // Declarations
    // ********************************************************
    logic run_q, run_d;
    logic [7:0] ctrl1_q, ctrl1_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] cmpa_q, cmpa_d;
    logic [7:0] cmpp_q, cmpp_d;
    logic flag_a_q, flag_a_d;
    logic flag_p_q, flag_p_d;
    logic lvl_q, lvl_d;
    logic pin_q, pin_d;
    logic [7:0] rdata_q, rdata_d;
    logic [15:0] div_q, div_d;
    logic tick;
    logic [1:0] mode, io;
    logic oc, pol, dpx, cclr;
    logic is_cmp, is_cap, is_pwm, is_sp;
    logic run_rise, step;
    logic [15:0] inc;
    logic ovf, a_hit, p_hit, a_set, p_set, clr;
    logic cap_rise, cap_fall, trig_rise, cap_evt;
    logic pwm_act, act;
    logic [16:0] duty;

    // Period compare on the upper byte; zero means the full range
    function automatic logic p_match(input logic [15:0] v,
                                     input logic [7:0] p,
                                     input logic o);
        p_match = (p == STM_DATA_ZERO) ? o
                : (v[15:8] == p && v[7:0] == STM_DATA_ZERO);
    endfunction

    // Period value in timer clocks as 17 bits, zero standing for 65536
    function automatic logic [16:0] p_span(input logic [7:0] p);
        p_span = (p == STM_DATA_ZERO) ? {1'b1, 16'h0000}
               : {1'b0, p, STM_DATA_ZERO};
    endfunction

    // ********************************************************
    // Configuration decode
    // ********************************************************
    assign mode = ctrl1_q[STM_MODE_HI:STM_MODE_LO];
    assign io = ctrl1_q[STM_IO_HI:STM_IO_LO];
    assign oc = ctrl1_q[STM_OC_BIT];
    assign pol = ctrl1_q[STM_POL_BIT];
    assign dpx = ctrl1_q[STM_DPX_BIT];
    assign cclr = ctrl1_q[STM_CCLR_BIT];
    assign is_cmp = (mode == STM_MODE_CMP) || (mode == STM_MODE_TMR);
    assign is_cap = (mode == STM_MODE_CAP);
    assign is_pwm = (mode == STM_MODE_PWM) && (io != STM_IO_11);
    assign is_sp = (mode == STM_MODE_PWM) && (io == STM_IO_11);

    // Pin edge detectors for capture input and trigger input
    stm_edge u_cap_edge (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_pin(I_CAP_PIN),
        .o_rise(cap_rise),
        .o_fall(cap_fall)
    );
    stm_edge u_trig_edge (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_pin(I_TRIG_PIN),
        .o_rise(trig_rise),
        .o_fall()
    );

    // ********************************************************
    // Timer clock divider
    // ********************************************************
    // Timer clock is a one-cycle enable; TICK_DIV=1 counts every cycle
    always_comb begin
        tick = (div_q == 16'(TICK_DIV - 1));
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
    end

    // ********************************************************
    // Comparators and counter
    // ********************************************************
    always_comb begin
        inc = cnt_q + 16'h0001;
        ovf = (cnt_q == STM_CNT_MAX);
        step = run_q && tick;
        a_hit = (cmpa_q != 16'h0000) && (inc == cmpa_q);
        p_hit = p_match(inc, cmpp_q, ovf);
        // Which comparator ends the count in each mode
        clr = 1'b0;
        if (is_cmp) begin
            clr = cclr ? a_hit : p_hit;
        end else if (is_pwm) begin
            clr = dpx ? (a_hit || (cmpa_q == 16'h0000 && ovf))
                      : p_hit;
        end else if (is_cap) begin
            clr = p_hit;
        end
        // Single pulse never clears on a match
        a_set = step && a_hit && !is_cap && !(is_cmp && !cclr && p_hit
                && cmpa_q > {cmpp_q, STM_DATA_ZERO});
        p_set = step && p_hit && !is_sp && !(is_cmp && cclr);
        run_rise = run_d && !run_q;
        if (run_rise) begin
            cnt_d = 16'h0000;
        end else if (step) begin
            cnt_d = clr ? 16'h0000 : inc;
        end else begin
            cnt_d = cnt_q;
        end
    end

    // ********************************************************
    // Capture
    // ********************************************************
    always_comb begin
        case (io)
            STM_IO_00: cap_evt = cap_rise;
            STM_IO_01: cap_evt = cap_fall;
            STM_IO_10: cap_evt = cap_rise || cap_fall;
            default: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt && is_cap;
    end

    // ********************************************************
    // Register writes, run bit and flags
    // ********************************************************
    // Hardware sets win over software clears in the same cycle
    always_comb begin
        run_d = run_q;
        ctrl1_d = ctrl1_q;
        cmpa_d = cmpa_q;
        cmpp_d = cmpp_q;
        flag_a_d = flag_a_q;
        flag_p_d = flag_p_q;
        if (I_WR) begin
            case (I_ADDR)
                STM_REG_CTRL0: run_d = I_WDATA[STM_RUN_BIT];
                STM_REG_CTRL1: ctrl1_d = I_WDATA;
                STM_REG_CMPA_L: cmpa_d[7:0] = I_WDATA;
                STM_REG_CMPA_H: cmpa_d[15:8] = I_WDATA;
                STM_REG_CMPP: cmpp_d = I_WDATA;
                STM_REG_FLAGS: begin
                    if (I_WDATA[STM_FLAG_A_BIT]) begin
                        flag_a_d = 1'b0;
                    end
                    if (I_WDATA[STM_FLAG_P_BIT]) begin
                        flag_p_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (is_sp && !run_q && trig_rise) begin
            run_d = 1'b1;
        end
        if (is_sp && a_set) begin
            run_d = 1'b0;
        end
        if (cap_evt) begin
            cmpa_d = cnt_q;
        end
        if (a_set || cap_evt) begin
            flag_a_d = 1'b1;
        end
        if (p_set) begin
            flag_p_d = 1'b1;
        end
    end

    // ********************************************************
    // Output pin
    // ********************************************************
    always_comb begin
        duty = dpx ? p_span(cmpp_q) : {1'b0, cmpa_q};
        pwm_act = ({1'b0, cnt_q} < duty);
        case (io)
            STM_IO_00: act = 1'b0;
            STM_IO_01: act = 1'b1;
            default: act = pwm_act;
        endcase
        if (is_sp) begin
            act = run_q;
        end
        lvl_d = lvl_q;
        if (run_rise) begin
            lvl_d = oc;
        end else if (mode == STM_MODE_CMP && a_set) begin
            case (io)
                STM_IO_01: lvl_d = 1'b0;
                STM_IO_10: lvl_d = 1'b1;
                STM_IO_11: lvl_d = ~lvl_q;
                default: lvl_d = lvl_q;
            endcase
        end
        // Active level chosen by the initial-level bit, then inverted when the polarity bit is set
        if (mode == STM_MODE_PWM) begin
            pin_d = (act ? oc : ~oc) ^ pol;
        end else begin
            pin_d = lvl_d ^ pol;
        end
    end

    // Pin released in timer/counter and capture modes
    assign O_TMR_OE = (mode == STM_MODE_CMP)
                   || (mode == STM_MODE_PWM);
    assign O_TMR_OUT = pin_q;

    // ********************************************************
    // Read port
    // ********************************************************
    // Data stands only in the cycle after the strobe
    always_comb begin
        rdata_d = STM_DATA_ZERO;
        if (I_RD) begin
            case (I_ADDR)
                STM_REG_CTRL0: rdata_d = {7'h00, run_q};
                STM_REG_CTRL1: rdata_d = ctrl1_q;
                STM_REG_CNT_L: rdata_d = cnt_q[7:0];
                STM_REG_CNT_H: rdata_d = cnt_q[15:8];
                STM_REG_CMPA_L: rdata_d = cmpa_q[7:0];
                STM_REG_CMPA_H: rdata_d = cmpa_q[15:8];
                STM_REG_CMPP: rdata_d = cmpp_q;
                STM_REG_FLAGS: rdata_d = {6'h00, flag_p_q, flag_a_q};
                default: rdata_d = STM_DATA_ZERO;
            endcase
        end
    end
    assign O_RDATA = rdata_q;

    // ********************************************************
    // State registers
    // ********************************************************
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            run_q <= 1'b0;
            ctrl1_q <= STM_CTRL_RST;
            cnt_q <= 16'h0000;
            cmpa_q <= 16'h0000;
            cmpp_q <= STM_DATA_ZERO;
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
            lvl_q <= 1'b0;
            pin_q <= 1'b0;
            rdata_q <= STM_DATA_ZERO;
            div_q <= 16'h0000;
        end else begin
            run_q <= run_d;
            ctrl1_q <= ctrl1_d;
            cnt_q <= cnt_d;
            cmpa_q <= cmpa_d;
            cmpp_q <= cmpp_d;
            flag_a_q <= flag_a_d;
            flag_p_q <= flag_p_d;
            lvl_q <= lvl_d;
            pin_q <= pin_d;
            rdata_q <= rdata_d;
            div_q <= div_d;
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    property p_ovf_clear;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (is_cmp && !cclr && cmpp_q == STM_DATA_ZERO && step && ovf
         && !run_rise) |=> (cnt_q == 16'h0000) && flag_p_q;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overflow did not clear counter and set P flag");

    property p_no_pflag;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (is_cmp && cclr && !flag_p_q && !I_WR) |=> !flag_p_q;
    endproperty
    a_no_pflag: assert property (p_no_pflag)
        else $error("P flag set with compare A clear select");

    property p_zero_a;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (is_cmp && cmpa_q == 16'h0000 && !flag_a_q && !I_WR)
        |=> !flag_a_q;
    endproperty
    a_zero_a: assert property (p_zero_a)
        else $error("A flag raised with zero compare A");

    property p_init_lvl;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (mode == STM_MODE_CMP && run_rise) |=> (pin_q == (oc ^ pol));
    endproperty
    a_init_lvl: assert property (p_init_lvl)
        else $error("pin not loaded with initial level");

    property p_toggle;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (mode == STM_MODE_CMP && io == STM_IO_11 && a_set && !run_rise
         && !I_WR) |=> (pin_q != $past(pin_q));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pin did not toggle on A match");

    property p_release;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (mode == STM_MODE_TMR) |-> !O_TMR_OE;
    endproperty
    a_release: assert property (p_release)
        else $error("pin driven in timer/counter mode");

    property p_force;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (mode == STM_MODE_PWM && io == STM_IO_01 && !I_WR)
        |=> (pin_q == (oc ^ pol));
    endproperty
    a_force: assert property (p_force)
        else $error("forced active level not on pin");

    property p_sp_end;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (is_sp && step && a_hit && !I_WR) |=> !run_q ##1 (pin_q == ~oc ^ pol);
    endproperty
    a_sp_end: assert property (p_sp_end)
        else $error("single pulse did not end on A match");

    property p_capture;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        cap_evt |=> (cmpa_q == $past(cnt_q)) && flag_a_q;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not load compare A");

    property p_cap_off;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (is_cap && io == STM_IO_11) |-> !cap_evt;
    endproperty
    a_cap_off: assert property (p_cap_off)
        else $error("capture taken while disabled");

    c_pwm_wrap: cover property (@(posedge I_CLK) is_pwm && step && clr);
    c_sp_end: cover property (@(posedge I_CLK) is_sp && a_set);
    c_capture: cover property (@(posedge I_CLK) cap_evt);
endmodule
`default_nettype wire

// ### tb/stm_pin_model.sv
// Model of the pins beside the timer: capture and trigger sources, load
`timescale 1ns/1ps
`default_nettype none
module stm_pin_model (
    input wire logic i_clk,
    input wire logic i_cap_lvl,
    input wire logic i_trig_lvl,
    input wire logic i_tmr_out,
    input wire logic i_tmr_oe,
    output logic o_cap_pin,
    output logic o_trig_pin,
    output logic [31:0] o_high_cnt
);
    // Quiet pins and an empty tally before the first edge
    initial begin
        o_cap_pin = 1'b0;
        o_trig_pin = 1'b0;
        o_high_cnt = 32'h0;
    end

    // Pins move just after an edge, as a synchronous source would
    always @(posedge i_clk) begin
        o_cap_pin <= i_cap_lvl;
        o_trig_pin <= i_trig_lvl;
    end

    // Load side: counts cycles the pin is driven high; undriven is not high
    always @(posedge i_clk) begin
        if (i_tmr_oe === 1'b1 && i_tmr_out === 1'b1) begin
            o_high_cnt <= o_high_cnt + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ### tb/test_stm_timer.sv
// Self-checking testbench for the standard timer operating modes
`timescale 1ns/1ps
`default_nettype none
module test_stm_timer
    import stm_pkg::*;
;
    logic clk, rst, wr, rd, cap_lvl, trig_lvl;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d8;
    logic tmr_out, tmr_oe, cap_pin, trig_pin;
    logic [31:0] high_cnt, h0;
    logic [15:0] v;
    logic [3:0] rise_e = 4'h5;
    logic [3:0] fall_e = 4'h6;
    int mismatches = 0;
    int checked = 0;

    stm_timer #(.TICK_DIV(1)) i_stm_timer (.I_CLK(clk), .I_SYS_RST(rst),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_CAP_PIN(cap_pin), .I_TRIG_PIN(trig_pin),
        .O_TMR_OUT(tmr_out), .O_TMR_OE(tmr_oe));
    stm_pin_model i_stm_pin_model (.i_clk(clk), .i_cap_lvl(cap_lvl),
        .i_trig_lvl(trig_lvl), .i_tmr_out(tmr_out), .i_tmr_oe(tmr_oe),
        .o_cap_pin(cap_pin), .o_trig_pin(trig_pin), .o_high_cnt(high_cnt));

    // ****************************************************************
    // Bus tasks and comparisons
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the read edge
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd16(input logic [3:0] a, output logic [15:0] d);
        logic [7:0] lo, hi;
        rd_reg(a, lo);
        rd_reg(a + 4'h1, hi);
        d = {hi, lo};
    endtask

    task automatic set_ap(input logic [15:0] a, input logic [7:0] p);
        wr_reg(STM_REG_CMPA_L, a[7:0]);
        wr_reg(STM_REG_CMPA_H, a[15:8]);
        wr_reg(STM_REG_CMPP, p);
    endtask

    // Stop first: mode and pin function are only changed while stopped
    task automatic arm(input logic [7:0] c1, input logic run);
        wr_reg(STM_REG_CTRL0, 8'h00);
        wr_reg(STM_REG_FLAGS, 8'h03);
        wr_reg(STM_REG_CTRL1, c1);
        wr_reg(STM_REG_CTRL0, {7'h0, run});
    endtask

    task automatic flags(input logic [7:0] exp, input string what);
        rd_reg(STM_REG_FLAGS, d8);
        chk({8'h0, d8}, {8'h0, exp}, what);
    endtask

    // One PWM set-up, then driven-high cycles over whole periods
    task automatic pwm(input logic [7:0] c1, input logic [15:0] a,
                       input logic [7:0] p, input int n, input int exp);
        set_ap(a, p);
        arm(c1, 1'b1);
        repeat (4) @(posedge clk);
        h0 = high_cnt;
        repeat (n) @(posedge clk);
        chk(16'(high_cnt - h0), 16'(exp), "pwm high cycles");
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is about 70k cycles, mostly the full-range overflow wait
    initial begin
        #950us;
        mismatches++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        cap_lvl = 1'b0;
        trig_lvl = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset state and an unmapped place
        rd_reg(STM_REG_CTRL1, d8);
        chk({8'h0, d8}, 16'h0, "ctrl1 after reset");
        wr_reg(4'h9, 8'h5a);
        rd_reg(4'h9, d8);
        chk({8'h0, d8}, 16'h0, "unmapped read");
        chk({15'h0, tmr_oe}, 16'h1, "oe in compare mode");
        // Compare mode, clear on P, toggle on A
        set_ap(16'h0010, 8'h01);
        arm({STM_MODE_CMP, STM_IO_11, 4'h0}, 1'b1);
        repeat (100) @(posedge clk);
        flags(8'h01, "A flag only before P");
        chk({15'h0, tmr_out}, 16'h1, "toggle on A");
        repeat (200) @(posedge clk);
        flags(8'h03, "both flags");
        chk({15'h0, tmr_out}, 16'h0, "second toggle");
        // Clear on A, P below A never flags
        set_ap(16'h0180, 8'h01);
        arm({STM_MODE_CMP, STM_IO_10, 4'h1}, 1'b1);
        repeat (600) @(posedge clk);
        flags(8'h01, "no P flag");
        rd_reg(STM_REG_CNT_H, d8);
        chk({8'h0, d8}, 16'h0, "cleared on A");
        chk({15'h0, tmr_out}, 16'h1, "high on A");
        wr_reg(STM_REG_CTRL0, 8'h00);
        wr_reg(STM_REG_CTRL0, 8'h01);
        repeat (3) @(posedge clk);
        chk({15'h0, tmr_out}, 16'h0, "initial level");
        // Timer/counter mode
        set_ap(16'h0010, 8'h01);
        arm({STM_MODE_TMR, STM_IO_11, 4'h0}, 1'b1);
        repeat (300) @(posedge clk);
        flags(8'h03, "timer flags");
        chk({15'h0, tmr_oe}, 16'h0, "pin released");
        // Zero compare A and zero period: full range, overflow clears
        // Timer/counter mode, since compare mode forbids a zero compare A
        set_ap(16'h0000, 8'h00);
        arm({STM_MODE_TMR, STM_IO_11, 4'h0}, 1'b1);
        repeat (65600) @(posedge clk);
        flags(8'h02, "overflow flags, no A flag");
        rd_reg(STM_REG_CNT_H, d8);
        chk({8'h0, d8}, 16'h0, "cleared on overflow");
        // PWM cases
        pwm(8'ha8, 16'h0040, 8'h01, 256, 64);
        pwm(8'hac, 16'h0040, 8'h01, 256, 192);
        pwm(8'ha0, 16'h0040, 8'h01, 256, 192);
        pwm(8'h88, 16'h0040, 8'h01, 256, 0);
        pwm(8'h98, 16'h0040, 8'h01, 256, 256);
        pwm(8'ha8, 16'h0200, 8'h01, 256, 256);
        pwm(8'haa, 16'h0300, 8'h01, 768, 256);
        pwm(8'ha9, 16'h0040, 8'h01, 256, 64);
        flags(8'h03, "pwm flags");
        // Single pulse from the trigger pin
        set_ap(16'h0040, 8'h01);
        arm({STM_MODE_PWM, STM_IO_11, 4'h8}, 1'b0);
        h0 = high_cnt;
        trig_lvl <= 1'b1;
        repeat (3) @(posedge clk);
        trig_lvl <= 1'b0;
        repeat (200) @(posedge clk);
        v = 16'(high_cnt - h0);
        chk({15'h0, v >= 16'h3f && v <= 16'h41}, 16'h1, "width");
        rd_reg(STM_REG_CTRL0, d8);
        chk({8'h0, d8}, 16'h0, "run cleared by A");
        flags(8'h01, "pulse flags");
        // Capture: P period, then copy of a held count
        set_ap(16'h0000, 8'h01);
        arm({STM_MODE_CAP, STM_IO_00, 4'h0}, 1'b1);
        repeat (300) @(posedge clk);
        flags(8'h02, "period flag");
        wr_reg(STM_REG_CTRL0, 8'h00);
        rd16(STM_REG_CNT_L, v);
        cap_lvl <= 1'b1;
        repeat (4) @(posedge clk);
        rd16(STM_REG_CMPA_L, h0[15:0]);
        chk(h0[15:0], v, "captured count");
        flags(8'h03, "capture flag");
        // Each edge select against both edges
        for (int f = 0; f < 4; f++) begin
            wr_reg(STM_REG_CTRL1, {STM_MODE_CAP, 2'(f), 4'h0});
            wr_reg(STM_REG_FLAGS, 8'h03);
            cap_lvl <= 1'b0;
            repeat (4) @(posedge clk);
            flags({7'h0, fall_e[f]}, "falling edge");
            wr_reg(STM_REG_FLAGS, 8'h03);
            cap_lvl <= 1'b1;
            repeat (4) @(posedge clk);
            flags({7'h0, rise_e[f]}, "rising edge");
        end
        wr_reg(STM_REG_CTRL0, 8'h01);
        repeat (20) @(posedge clk);
        rd16(STM_REG_CNT_L, v);
        chk({15'h0, v != 16'h0}, 16'h1, "counter runs");
        conclude();
    end
endmodule
`default_nettype wire
